//--- tmr2_pkg.sv
package tmr2_pkg;
    localparam logic [7:0] TMR2_OFS_CONTROL   = 8'hC8;
    localparam logic [7:0] TMR2_OFS_MODE      = 8'hC9;
    localparam logic [7:0] TMR2_OFS_RCMP_LOW  = 8'hCA;
    localparam logic [7:0] TMR2_OFS_RCMP_HIGH = 8'hCB;
    localparam logic [7:0] TMR2_OFS_CNT_LOW   = 8'hCC;
    localparam logic [7:0] TMR2_OFS_CNT_HIGH  = 8'hCD;
    localparam logic [7:0] TMR2_OFS_CAP0_LOW  = 8'hE0;
    localparam logic [7:0] TMR2_OFS_CAP0_HIGH = 8'hE1;
    localparam logic [7:0] TMR2_OFS_CAP1_LOW  = 8'hE2;
    localparam logic [7:0] TMR2_OFS_CAP1_HIGH = 8'hE3;
    localparam logic [7:0] TMR2_OFS_CAP2_LOW  = 8'hE4;
    localparam logic [7:0] TMR2_OFS_CAP2_HIGH = 8'hE5;
    localparam logic [7:0] TMR2_OFS_IE        = 8'hE6;
    localparam int         TMR2_BIT_FLAG      = 7;
    localparam int         TMR2_BIT_RUN       = 2;
    localparam int         TMR2_BIT_MODE      = 0;
    localparam int         TMR2_BIT_RELOAD_ENABLE      = 7;
    localparam int         TMR2_DIV_HI        = 6;
    localparam int         TMR2_DIV_LO        = 4;
    localparam int         TMR2_BIT_CAPCLR    = 3;
    localparam int         TMR2_BIT_CMPCLR    = 2;
    localparam int         TMR2_TRIG_HI       = 1;
    localparam int         TMR2_TRIG_LO       = 0;
    localparam int         TMR2_BIT_IE_TMR    = 0;
    localparam int         TMR2_BIT_IE_GLB    = 1;
    localparam logic [7:0] TMR2_CONTROL_MASK  = 8'h85;
    localparam logic [7:0] TMR2_RST_BYTE      = 8'h00;
    localparam logic [15:0] TMR2_RST_WORD     = 16'h0000;
    localparam logic [15:0] TMR2_CNT_MAX      = 16'hFFFF;
    localparam logic [8:0] TMR2_PRE_ZERO      = 9'h000;
    localparam logic [1:0] TMR2_TRIG_OVF      = 2'h0;
    localparam int         TMR2_NUM_CAP       = 3;
endpackage

//--- tmr2_prescaler.sv
`timescale 1ns/100ps
`default_nettype none
module tmr2_prescaler
    import tmr2_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       run,
    input  wire logic [2:0] sel,
    output logic            tick
);
    logic [8:0] cnt_ff;
    logic [8:0] nxt_cnt;
    logic [8:0] last;

    // terminal count for the chosen ratio
    function automatic logic [8:0] div_last(input logic [2:0] s);
        unique case (s)
            3'h0: div_last = 9'h000;
            3'h1: div_last = 9'h003;
            3'h2: div_last = 9'h00F;
            3'h3: div_last = 9'h01F;
            3'h4: div_last = 9'h03F;
            3'h5: div_last = 9'h07F;
            3'h6: div_last = 9'h0FF;
            default: div_last = 9'h1FF;
        endcase
    endfunction

    always_comb begin
        last = div_last(sel);
        tick = run && (cnt_ff >= last);
        if (!run || tick) begin
            nxt_cnt = TMR2_PRE_ZERO;
        end else begin
            nxt_cnt = cnt_ff + 9'h001;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_ff <= TMR2_PRE_ZERO;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end
endmodule
`default_nettype wire

//--- tmr2_timer.sv
// Function
// - 16-bit up counter held as high and low count bytes.
// - prescaler field bits 6:4 divides clock by 1,4,16,32,64,128,256,512.
// - counter advances only while run bit set; clearing stops increments, but captures can still reload or clear the count.
// - control bit 0 picks auto-reload (0) or compare (1).
// - flag bit 7 set on overflow or match; only software clears it.
// - interrupt request when flag, timer enable and global enable all set.
// - reload copies reload pair only when reload enable bit set.
// - trigger field 1:0 selects overflow or capture channel 0,1,2.
// - auto-reload mode loads count from reload pair on selected event.
// - auto-reload with capture auto-clear zeroes counter on capture.
// - with capture auto-clear, capture only clears, never reloads.
// - compare mode sets flag when counter equals compare pair while run bit set.
// - compare mode with match auto-clear zeroes counter after match.
// - reload/compare pair is software readable and writable as bytes.
// - every capture copies count to its result register before any clear.
`timescale 1ns/100ps
`default_nettype none
module tmr2_timer
    import tmr2_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic [2:0] cap_event,
    output logic            irq_req
);
    ////////////////////////////////////////////////////////////////////
    logic [7:0]  ctrl_ff;
    logic [7:0]  nxt_ctrl;
    logic [7:0]  mode_ff;
    logic [7:0]  nxt_mode;
    logic [15:0] rcmp_ff;
    logic [15:0] nxt_rcmp;
    logic [15:0] cnt_ff;
    logic [15:0] nxt_cnt;
    logic [15:0] cap_ff [TMR2_NUM_CAP];
    logic [15:0] nxt_cap [TMR2_NUM_CAP];
    logic [1:0]  ie_ff;
    logic [1:0]  nxt_ie;
    logic [7:0]  rdata_ff;
    logic [7:0]  nxt_rdata;

    logic        tick;
    logic        run;
    logic        cmp_mode;
    logic        ovf;
    logic        match;
    logic        cap_any;
    logic        trig_cap;
    logic        reload_evt;
    logic        set_flag;
    logic [1:0]  trig_sel;
    logic [15:0] cnt_inc;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = reg_wr && (a == o);
    endfunction

    ////////////////////////////////////////////////////////////////////
    assign run      = ctrl_ff[TMR2_BIT_RUN];
    assign cmp_mode = ctrl_ff[TMR2_BIT_MODE];
    assign trig_sel = mode_ff[TMR2_TRIG_HI:TMR2_TRIG_LO];

    tmr2_prescaler u_pre (
        .clk     (clk),
        .sys_rst (sys_rst),
        .run     (run),
        .sel     (mode_ff[TMR2_DIV_HI:TMR2_DIV_LO]),
        .tick    (tick)
    );

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        cnt_inc  = cnt_ff + 16'h0001;
        ovf      = tick && (cnt_ff == TMR2_CNT_MAX);
        // match checked on the value the count just reached
        match    = cmp_mode && run && (cnt_ff == rcmp_ff);
        cap_any  = |cap_event;
        // a capture only triggers on its own channel, never out of range
        unique case (trig_sel)
            2'h0: trig_cap = 1'b0;
            2'h1: trig_cap = cap_event[0];
            2'h2: trig_cap = cap_event[1];
            2'h3: trig_cap = cap_event[2];
        endcase
        reload_evt = (trig_sel == TMR2_TRIG_OVF) ? ovf : trig_cap;
        set_flag = ovf || match;

        nxt_cnt = cnt_ff;
        if (tick) begin
            nxt_cnt = cnt_inc;
        end
        if (!cmp_mode) begin
            if (mode_ff[TMR2_BIT_CAPCLR] && cap_any) begin
                nxt_cnt = TMR2_RST_WORD;
            end else if (reload_evt && mode_ff[TMR2_BIT_RELOAD_ENABLE]) begin
                nxt_cnt = rcmp_ff;
            end
        end else if (match && mode_ff[TMR2_BIT_CMPCLR]) begin
            // clear lands one cycle after the match is seen
            nxt_cnt = TMR2_RST_WORD;
        end
        if (hit(reg_addr, TMR2_OFS_CNT_LOW)) begin
            nxt_cnt[7:0] = reg_wdata;
        end
        if (hit(reg_addr, TMR2_OFS_CNT_HIGH)) begin
            nxt_cnt[15:8] = reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_mode = mode_ff;
        nxt_rcmp = rcmp_ff;
        nxt_ie   = ie_ff;
        for (int i = 0; i < TMR2_NUM_CAP; i++) begin
            nxt_cap[i] = cap_ff[i];
            if (cap_event[i]) begin
                nxt_cap[i] = cnt_ff;
            end
        end
        if (hit(reg_addr, TMR2_OFS_CONTROL)) begin
            nxt_ctrl = reg_wdata & TMR2_CONTROL_MASK;
        end
        // hardware set beats a same-cycle software clear
        if (set_flag) begin
            nxt_ctrl[TMR2_BIT_FLAG] = 1'b1;
        end
        if (hit(reg_addr, TMR2_OFS_MODE)) begin
            nxt_mode = reg_wdata;
        end
        if (hit(reg_addr, TMR2_OFS_RCMP_LOW)) begin
            nxt_rcmp[7:0] = reg_wdata;
        end
        if (hit(reg_addr, TMR2_OFS_RCMP_HIGH)) begin
            nxt_rcmp[15:8] = reg_wdata;
        end
        if (hit(reg_addr, TMR2_OFS_IE)) begin
            nxt_ie = reg_wdata[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_rdata = TMR2_RST_BYTE;
        if (reg_rd) begin
            unique case (reg_addr)
                TMR2_OFS_CONTROL:   nxt_rdata = ctrl_ff;
                TMR2_OFS_MODE:      nxt_rdata = mode_ff;
                TMR2_OFS_RCMP_LOW:  nxt_rdata = rcmp_ff[7:0];
                TMR2_OFS_RCMP_HIGH: nxt_rdata = rcmp_ff[15:8];
                TMR2_OFS_CNT_LOW:   nxt_rdata = cnt_ff[7:0];
                TMR2_OFS_CNT_HIGH:  nxt_rdata = cnt_ff[15:8];
                TMR2_OFS_CAP0_LOW:  nxt_rdata = cap_ff[0][7:0];
                TMR2_OFS_CAP0_HIGH: nxt_rdata = cap_ff[0][15:8];
                TMR2_OFS_CAP1_LOW:  nxt_rdata = cap_ff[1][7:0];
                TMR2_OFS_CAP1_HIGH: nxt_rdata = cap_ff[1][15:8];
                TMR2_OFS_CAP2_LOW:  nxt_rdata = cap_ff[2][7:0];
                TMR2_OFS_CAP2_HIGH: nxt_rdata = cap_ff[2][15:8];
                TMR2_OFS_IE:        nxt_rdata = {6'h00, ie_ff};
                default:            nxt_rdata = TMR2_RST_BYTE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_ff <= TMR2_RST_WORD;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_ff <= TMR2_RST_BYTE;
            mode_ff <= TMR2_RST_BYTE;
            rcmp_ff <= TMR2_RST_WORD;
            ie_ff   <= 2'h0;
            for (int i = 0; i < TMR2_NUM_CAP; i++) begin
                cap_ff[i] <= TMR2_RST_WORD;
            end
        end else begin
            ctrl_ff <= nxt_ctrl;
            mode_ff <= nxt_mode;
            rcmp_ff <= nxt_rcmp;
            ie_ff   <= nxt_ie;
            for (int i = 0; i < TMR2_NUM_CAP; i++) begin
                cap_ff[i] <= nxt_cap[i];
            end
        end
    end

    // read data lasts one cycle, then falls back to zero
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_ff <= TMR2_RST_BYTE;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;
    assign irq_req   = ctrl_ff[TMR2_BIT_FLAG] && ie_ff[TMR2_BIT_IE_TMR]
                       && ie_ff[TMR2_BIT_IE_GLB];

    ////////////////////////////////////////////////////////////////////
    AST_HALT_HOLDS: assert property (
        @(posedge clk) disable iff (sys_rst)
        !run && !reg_wr && !(|cap_event) |=> $stable(cnt_ff))
        else $error("count moved while halted");
    AST_FLAG_STICKY: assert property (
        @(posedge clk) disable iff (sys_rst)
        ctrl_ff[TMR2_BIT_FLAG] && !reg_wr |=> ctrl_ff[TMR2_BIT_FLAG])
        else $error("flag cleared by hardware");
    AST_OVF_FLAG: assert property (
        @(posedge clk) disable iff (sys_rst)
        ovf |=> ctrl_ff[TMR2_BIT_FLAG])
        else $error("overflow did not set flag");
    AST_WRAP: assert property (
        @(posedge clk) disable iff (sys_rst)
        ovf && !cmp_mode && !mode_ff[TMR2_BIT_RELOAD_ENABLE] && !(|cap_event)
        && !reg_wr |=> cnt_ff == TMR2_RST_WORD)
        else $error("no wrap to zero");
    AST_RELOAD: assert property (
        @(posedge clk) disable iff (sys_rst)
        !cmp_mode && ovf && mode_ff[TMR2_BIT_RELOAD_ENABLE] && trig_sel == 2'h0
        && !(|cap_event) && !reg_wr |=> cnt_ff == $past(rcmp_ff))
        else $error("reload value not loaded");
    AST_CAPCLR: assert property (
        @(posedge clk) disable iff (sys_rst)
        !cmp_mode && mode_ff[TMR2_BIT_CAPCLR] && cap_event[0] && !reg_wr
        |=> cnt_ff == TMR2_RST_WORD && cap_ff[0] == $past(cnt_ff))
        else $error("capture clear or copy wrong");
    AST_MATCH: assert property (
        @(posedge clk) disable iff (sys_rst)
        cmp_mode && run && cnt_ff == rcmp_ff |=> ctrl_ff[TMR2_BIT_FLAG])
        else $error("match did not set flag");
    AST_CMPCLR: assert property (
        @(posedge clk) disable iff (sys_rst)
        match && mode_ff[TMR2_BIT_CMPCLR] && !reg_wr
        |=> cnt_ff == TMR2_RST_WORD)
        else $error("match clear missing");
    AST_IRQ: assert property (
        @(posedge clk) disable iff (sys_rst)
        irq_req == (ctrl_ff[7] && ie_ff == 2'h3))
        else $error("irq gating wrong");
    AST_NOLOAD_OFF: assert property (
        @(posedge clk) disable iff (sys_rst)
        !cmp_mode && !mode_ff[TMR2_BIT_RELOAD_ENABLE] && !(|cap_event) && !reg_wr
        && !tick |=> $stable(cnt_ff))
        else $error("load while disabled");
    AST_HALT_NO_TICK: assert property (
        @(posedge clk) disable iff (sys_rst)
        !run |-> !tick)
        else $error("prescaler ticked while halted");
    AST_DIV1_TICK: assert property (
        @(posedge clk) disable iff (sys_rst)
        run && mode_ff[TMR2_DIV_HI:TMR2_DIV_LO] == 3'h0 |-> tick)
        else $error("divide by one missed a tick");
    AST_DIV4_GAP: assert property (
        @(posedge clk) disable iff (sys_rst)
        tick && mode_ff[TMR2_DIV_HI:TMR2_DIV_LO] == 3'h1
        |=> (!tick || mode_ff[TMR2_DIV_HI:TMR2_DIV_LO] != 3'h1) [*3])
        else $error("divide by four ticked early");
    AST_CMP_NO_RELOAD: assert property (
        @(posedge clk) disable iff (sys_rst)
        cmp_mode && !tick && !match && !reg_wr |=> $stable(cnt_ff))
        else $error("count moved in compare mode");
    AST_FLAG_SW_CLR: assert property (
        @(posedge clk) disable iff (sys_rst)
        reg_wr && reg_addr == TMR2_OFS_CONTROL && !set_flag
        && !reg_wdata[TMR2_BIT_FLAG] |=> !ctrl_ff[TMR2_BIT_FLAG])
        else $error("software clear of flag lost");
    AST_TRIG_SEL: assert property (
        @(posedge clk) disable iff (sys_rst)
        !cmp_mode && mode_ff[TMR2_BIT_RELOAD_ENABLE] && !mode_ff[TMR2_BIT_CAPCLR]
        && trig_sel == 2'h2 && cap_event[1] && !reg_wr
        |=> cnt_ff == $past(rcmp_ff))
        else $error("selected capture did not reload");
    AST_TRIG_OTHER: assert property (
        @(posedge clk) disable iff (sys_rst)
        !cmp_mode && !mode_ff[TMR2_BIT_CAPCLR] && trig_sel == 2'h1
        && cap_event[1] && !cap_event[0] && !tick && !reg_wr
        |=> $stable(cnt_ff))
        else $error("unselected capture changed count");
    AST_CAP_KEEP: assert property (
        @(posedge clk) disable iff (sys_rst)
        !cmp_mode && !mode_ff[TMR2_BIT_CAPCLR] && cap_event[2] && !trig_cap
        && !tick && !reg_wr |=> $stable(cnt_ff))
        else $error("capture disturbed count");
    AST_CAPCLR_ONLY: assert property (
        @(posedge clk) disable iff (sys_rst)
        !cmp_mode && mode_ff[TMR2_BIT_CAPCLR] && mode_ff[TMR2_BIT_RELOAD_ENABLE]
        && trig_cap && !reg_wr |=> cnt_ff == TMR2_RST_WORD)
        else $error("capture reloaded instead of clearing");
    AST_MATCH_KEEP: assert property (
        @(posedge clk) disable iff (sys_rst)
        match && !mode_ff[TMR2_BIT_CMPCLR] && !tick && !reg_wr
        |=> $stable(cnt_ff))
        else $error("match cleared count while clear off");
    AST_RCMP_LOW_WR: assert property (
        @(posedge clk) disable iff (sys_rst)
        reg_wr && reg_addr == TMR2_OFS_RCMP_LOW
        |=> rcmp_ff[7:0] == $past(reg_wdata))
        else $error("reload low byte write lost");
    AST_RCMP_HIGH_WR: assert property (
        @(posedge clk) disable iff (sys_rst)
        reg_wr && reg_addr == TMR2_OFS_RCMP_HIGH
        |=> rcmp_ff[15:8] == $past(reg_wdata))
        else $error("reload high byte write lost");
    AST_CAP1_COPY: assert property (
        @(posedge clk) disable iff (sys_rst)
        cap_event[1] |=> cap_ff[1] == $past(cnt_ff))
        else $error("capture one copy wrong");
    AST_CAP2_COPY: assert property (
        @(posedge clk) disable iff (sys_rst)
        cap_event[2] |=> cap_ff[2] == $past(cnt_ff))
        else $error("capture two copy wrong");
endmodule
`default_nettype wire

//--- tmr2_cap_model.sv
`timescale 1ns/100ps
`default_nettype none
module tmr2_cap_model (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic [2:0] pin,
    output logic      [2:0] cap_ff
);
    logic [2:0] prev_ff;
    // registered, so a slow pin edge still gives exactly one pulse
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prev_ff <= 3'h0;
            cap_ff  <= 3'h0;
        end else begin
            prev_ff <= pin;
            cap_ff  <= pin & ~prev_ff;
        end
    end
endmodule
`default_nettype wire

//--- test_timer2_reload_compare.sv
`timescale 1ns/100ps
`default_nettype none
module test_timer2_reload_compare
    import tmr2_pkg::*;
;
    logic       clk       = 1'b0;
    logic       sys_rst   = 1'b1;
    logic [7:0] reg_addr  = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr    = 1'b0;
    logic       reg_rd    = 1'b0;
    logic [7:0] reg_rdata;
    logic [2:0] pin       = 3'h0;
    logic [2:0] cap_event;
    logic       irq_req;
    int         n_fail    = 0;
    int         compares  = 0;
    int         divs[8]   = '{1, 4, 16, 32, 64, 128, 256, 512};
    logic [7:0] offs[8]   = '{8'hC8, 8'hC9, 8'hCA, 8'hCB, 8'hCC, 8'hCD,
                              8'hE6, 8'h00};

    always #2.5 clk = ~clk;

    tmr2_timer dut (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .reg_addr  (reg_addr),
        .reg_wdata (reg_wdata),
        .reg_wr    (reg_wr),
        .reg_rd    (reg_rd),
        .reg_rdata (reg_rdata),
        .cap_event (cap_event),
        .irq_req   (irq_req)
    );
    tmr2_cap_model cap (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pin     (pin),
        .cap_ff  (cap_event)
    );
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // strobes dropped at the sampling edge, read data taken once settled
    task automatic acc(input logic [7:0] a, input logic [7:0] d,
                       input logic w, output logic [7:0] q);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= w;
        reg_rd    <= ~w;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        @(negedge clk);
        q = reg_rdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        acc(a, d, 1'b1, q);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        acc(a, 8'h00, 1'b0, q);
    endtask
    task automatic wrw(input logic [7:0] a, input logic [15:0] v);
        wr(a, v[7:0]);
        wr(a + 8'h01, v[15:8]);
    endtask
    task automatic rdw(input logic [7:0] a, output logic [15:0] v);
        rd(a, v[7:0]);
        rd(a + 8'h01, v[15:8]);
    endtask
    // runs n cycles; control and irq sampled just before the stop write
    task automatic run_for(input logic [7:0] ctl, input int n,
                           output logic [7:0] c, output logic i);
        wr(TMR2_OFS_CONTROL, ctl | 8'h04);
        repeat (n - 4) @(posedge clk);
        rd(TMR2_OFS_CONTROL, c);
        i = irq_req;
        wr(TMR2_OFS_CONTROL, ctl);
    endtask
    task automatic pulse(input int ch);
        @(posedge clk);
        pin[ch] <= 1'b1;
        repeat (3) @(posedge clk);
        pin[ch] <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        logic [7:0]  q;
        logic [15:0] v;
        foreach (offs[k]) begin
            rd(offs[k], q);
            chk("reset", 16'h0000, {8'h00, q});
        end
        wr(TMR2_OFS_CONTROL, 8'hFB);
        rd(TMR2_OFS_CONTROL, q);
        chk("ctl mask", 16'h0081, {8'h00, q});
        wr(TMR2_OFS_CONTROL, 8'h00);
        rd(TMR2_OFS_CONTROL, q);
        chk("ctl clr", 16'h0000, {8'h00, q});
        wrw(TMR2_OFS_RCMP_LOW, 16'hA55A);
        rdw(TMR2_OFS_RCMP_LOW, v);
        chk("rcmp", 16'hA55A, v);
        wr(8'h00, 8'hFF);
        rd(8'h00, q);
        chk("unmapped", 16'h0000, {8'h00, q});
        $display("regs done");
    endtask
    task automatic t_presc();
        logic [7:0]  c;
        logic        i;
        logic [15:0] v;
        for (int k = 0; k < 8; k++) begin
            wrw(TMR2_OFS_CNT_LOW, 16'h0000);
            wr(TMR2_OFS_MODE, {1'b0, 3'(k), 4'h0});
            run_for(8'h00, 4 * divs[k] + divs[k] / 2, c, i);
            rdw(TMR2_OFS_CNT_LOW, v);
            chk("presc", 16'h0004, v);
        end
        $display("presc done");
    endtask
    task automatic t_wrap(input logic ld);
        logic [7:0]  c;
        logic        i;
        logic [15:0] v;
        wr(TMR2_OFS_IE, 8'h03);
        wrw(TMR2_OFS_RCMP_LOW, 16'h1234);
        wrw(TMR2_OFS_CNT_LOW, 16'hFFFF);
        wr(TMR2_OFS_MODE, {ld, 7'h10});
        run_for(8'h00, 10, c, i);
        chk("ovf flag", 16'h0084, {8'h00, c});
        chk("ovf irq", 16'h0001, {15'h0, i});
        rdw(TMR2_OFS_CNT_LOW, v);
        chk("wrap", ld ? 16'h1235 : 16'h0001, v);
        $display("wrap done");
    endtask
    task automatic t_irq();
        wr(TMR2_OFS_CONTROL, 8'h80);
        chk("irq on", 16'h0001, {15'h0, irq_req});
        wr(TMR2_OFS_IE, 8'h01);
        chk("irq glb", 16'h0000, {15'h0, irq_req});
        wr(TMR2_OFS_IE, 8'h02);
        chk("irq tmr", 16'h0000, {15'h0, irq_req});
        wr(TMR2_OFS_IE, 8'h03);
        wr(TMR2_OFS_CONTROL, 8'h00);
        chk("irq clr", 16'h0000, {15'h0, irq_req});
        $display("irq done");
    endtask
    task automatic t_cap();
        logic [15:0] v;
        for (int ch = 0; ch < 3; ch++) begin
            wr(TMR2_OFS_MODE, 8'h80 | 8'(ch + 1));
            wrw(TMR2_OFS_CNT_LOW, 16'h0040 + 16'(ch));
            pulse((ch + 1) % 3);
            rdw(TMR2_OFS_CNT_LOW, v);
            chk("no trig", 16'h0040 + 16'(ch), v);
            rdw(TMR2_OFS_CAP0_LOW + 8'(2 * ((ch + 1) % 3)), v);
            chk("cap other", 16'h0040 + 16'(ch), v);
            pulse(ch);
            rdw(TMR2_OFS_CNT_LOW, v);
            chk("trig", 16'h1234, v);
        end
        wr(TMR2_OFS_MODE, 8'h89);
        wrw(TMR2_OFS_CNT_LOW, 16'h0077);
        pulse(0);
        rdw(TMR2_OFS_CNT_LOW, v);
        chk("cap clr", 16'h0000, v);
        rdw(TMR2_OFS_CAP0_LOW, v);
        chk("cap val", 16'h0077, v);
        $display("cap done");
    endtask
    task automatic t_cmp(input logic clr);
        logic [7:0]  c;
        logic        i;
        logic [15:0] v;
        wr(TMR2_OFS_MODE, clr ? 8'h14 : 8'h10);
        wrw(TMR2_OFS_RCMP_LOW, 16'h0005);
        wrw(TMR2_OFS_CNT_LOW, 16'h0000);
        run_for(8'h01, 26, c, i);
        chk("match", 16'h0085, {8'h00, c});
        rdw(TMR2_OFS_CNT_LOW, v);
        chk("cmp cnt", clr ? 16'h0001 : 16'h0006, v);
        $display("cmp done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        t_regs();
        t_presc();
        t_wrap(1'b0);
        t_wrap(1'b1);
        t_irq();
        t_cap();
        t_cmp(1'b0);
        t_cmp(1'b1);
        conclude();
    end
    // runs take about 5000 cycles; allow several times that
    initial begin
        #200000;
        n_fail++;
        conclude();
    end
endmodule
`default_nettype wire
